// [dv/aopc_host_model.sv]
/*
 Host serial controller model: captures serial result bits, measures
 clock high time and drives an external serial clock on request.
 Assumes the bench resolves pin levels and passes frame sync as active high.
*/
`timescale 1ns/100ps
`default_nettype none
module aopc_host_model (
	input wire logic clk_in,
	input wire logic gen_in,
	input wire logic sclk_in,
	input wire logic inv_in,
	input wire logic sync_in,
	input wire logic sdata_in,
	output logic sclk_out,
	output logic [31:0] word_out,
	output logic [3:0] width_out
);
	logic eff;
	logic prev_eff = 1'b0;
	logic prev_sync = 1'b0;
	logic [1:0] div = 2'd0;
	logic [3:0] cnt = 4'd0;
	assign eff = sclk_in ^ inv_in;
	initial sclk_out = 1'b0;
	// External clock of four system clocks, held low while gen_in is low
	always @(posedge clk_in) begin
		div <= gen_in ? div + 2'd1 : 2'd0;
		if (!gen_in) begin
			sclk_out <= 1'b0;
		end else if (div[0]) begin
			sclk_out <= ~sclk_out;
		end
	end
	// Sample data on rising clock in a frame, restart at frame start
	always @(posedge clk_in) begin
		prev_eff <= eff;
		prev_sync <= sync_in;
		if (sync_in && !prev_sync) begin
			word_out <= {31'h0, eff && !prev_eff && sdata_in};
		end else if (sync_in && eff && !prev_eff) begin
			word_out <= {word_out[30:0], sdata_in};
		end
		cnt <= eff ? cnt + 4'd1 : 4'd0;
		if (!eff && prev_eff) begin
			width_out <= cnt; // High time in system clocks
		end
	end
endmodule
`default_nettype wire

// [dv/aopc_top_tb.sv]
/*
 Self-checking bench for the result port: AHB-Lite tasks, parallel,
 serial master and serial slave sequences.
 Assumes the host model beside it and a 40 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module aopc_top_tb;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, gen = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hready, hresp, sclk_o, sclk_oe, fsync, sdata, host_sclk;
	logic [15:0] bus_o, bus_oe, tb_bus = 16'h0000, v;
	logic [31:0] word;
	logic [3:0] width;
	logic [3:0] half [4] = '{4'd1, 4'd1, 4'd2, 4'd4};
	wire logic [15:0] bus_in = (bus_oe & bus_o) | (~bus_oe & tb_bus);
	wire logic sclk = sclk_oe ? sclk_o : host_sclk;
	int error_cnt = 0, samples_checked = 0;
	always #12.5 clk_in = ~clk_in;
	aopc_top aopc_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .data_bus_in(bus_in),
		.data_bus_out(bus_o), .data_bus_oe_out(bus_oe), .sclk_in(sclk),
		.sclk_out(sclk_o), .sclk_oe_out(sclk_oe), .frame_sync_out(fsync),
		.serial_result_out(sdata));
	aopc_host_model aopc_host_model_inst (.clk_in(clk_in), .gen_in(gen), .sclk_in(sclk),
		.inv_in(tb_bus[6]), .sync_in(fsync ^ tb_bus[5]), .sdata_in(sdata),
		.sclk_out(host_sclk), .word_out(word), .width_out(width));
	// One single AHB-Lite transfer, waiting on hready in each phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
			error_cnt++;
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#(25 * 20000);
		error_cnt++;
		finish_test();
	end
	// Main sequence; selects change only between frames
	initial begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		ahb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0002, "ctrl reset");
		chk({31'h0, hresp}, 32'h0, "okay response");
		chk({16'h0, bus_oe}, 32'h0000_FFFF, "parallel drive");
		ahb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0000_0000, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, 8'h00, i);
			ahb(1'b1, 8'h04, 32'h0000_12C4);
			repeat (2) @(posedge clk_in);
			v = i[1] ? 16'h12C4 : 16'h92C4;
			v = i[0] ? {v[7:0], v[15:8]} : v;
			chk({16'h0, bus_o}, {16'h0, v}, "parallel word");
		end
		for (int i = 0; i < 4; i++) begin
			tb_bus <= {8'h0, 1'b0, i[1], i[0], 1'b0, i[1:0], 2'b00};
			ahb(1'b1, 8'h00, 32'h0000_0006);
			repeat (2) @(posedge clk_in);
			chk({16'h0, bus_oe}, 32'h0, "serial pins float");
			chk({31'h0, fsync}, {31'h0, i[0]}, "idle sync level");
			chk({31'h0, sclk_oe}, 32'h1, "internal clock out");
			ahb(1'b1, 8'h04, 32'h0000_B38E);
			repeat (200) @(posedge clk_in);
			chk(word, 32'h0000_B38E, "master frame");
			chk({28'h0, width}, {28'h0, half[i]}, "clock high time");
		end
		tb_bus <= 16'h008C;
		ahb(1'b1, 8'h04, 32'h0000_1357);
		ahb(1'b1, 8'h08, 32'h0000_0001);
		repeat (200) @(posedge clk_in);
		chk(word, 32'h0000_1357, "read during convert");
		chk({28'h0, width}, 32'h1, "divider ignored");
		tb_bus <= 16'h0090;
		ahb(1'b1, 8'h04, 32'h0000_4C2D);
		chk({31'h0, sclk_oe}, 32'h0, "host clock in");
		gen <= 1'b1;
		repeat (128) @(posedge clk_in);
		gen <= 1'b0;
		repeat (10) @(posedge clk_in);
		chk(word, 32'h4C2D_FFFF, "slave chain");
		ahb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0000_0090, "status after slave frame");
		finish_test();
	end
endmodule
`default_nettype wire

// [src/aopc_pkg.sv]
/*
 Shared constants and carrier types for the converter result port.
 Assumes a 40 MHz system clock and a single AHB-Lite master.
*/
package aopc_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RESULT = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	// Control field positions and reset value
	localparam int CTRL_BYTE_ORDER = 0;
	localparam int CTRL_CODING = 1;
	localparam int CTRL_PORT_TYPE = 2;
	localparam logic [2:0] CTRL_RESET = 3'h2;
	localparam int CMD_START = 0;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	// Shared pin positions on the data bus
	localparam int PIN_DIV_LO = 2;
	localparam int PIN_CLK_SRC = 4;
	localparam int PIN_FS_POL = 5;
	localparam int PIN_SCLK_INV = 6;
	localparam int PIN_TIMING_CHAIN = 7;
	// Serial frame lengths in clocks of the serial clock
	localparam logic [5:0] MASTER_BITS = 6'd16;
	localparam logic [5:0] SLAVE_BITS = 6'd32;
	// Internal serial clock minimum periods per divider code
	localparam int CLK_NS = 25;
	localparam int SCLK_NS_0 = 25;
	localparam int SCLK_NS_1 = 50;
	localparam int SCLK_NS_2 = 100;
	localparam int SCLK_NS_3 = 200;
	// Half periods in system clocks, rounded up
	localparam logic [3:0] HALF_0 = 4'((SCLK_NS_0 + 2 * CLK_NS - 1) / (2 * CLK_NS));
	localparam logic [3:0] HALF_1 = 4'((SCLK_NS_1 + 2 * CLK_NS - 1) / (2 * CLK_NS));
	localparam logic [3:0] HALF_2 = 4'((SCLK_NS_2 + 2 * CLK_NS - 1) / (2 * CLK_NS));
	localparam logic [3:0] HALF_3 = 4'((SCLK_NS_3 + 2 * CLK_NS - 1) / (2 * CLK_NS));
	// Software owned selects
	typedef struct packed {
		logic port_type;
		logic coding;
		logic byte_order;
	} aopc_ctrl_t;
	// Selects read from shared pins in serial mode
	typedef struct packed {
		logic timing_chain;
		logic sclk_inv;
		logic fs_pol;
		logic ext_clk;
		logic [1:0] div;
	} aopc_scfg_t;
	// Frame states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} aopc_state_t;
endpackage

// [src/aopc_shifter.sv]
/*
 Sixteen bit result shifter with a chain input at the low end.
 Assumes load and shift are one cycle strobes from the frame logic.
*/
`timescale 1ns/100ps
`default_nettype none
module aopc_shifter (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic load_in,
	input wire logic [15:0] load_data_in,
	input wire logic shift_in,
	input wire logic chain_in,
	output logic msb_out
);
	logic [15:0] bits;
	logic [15:0] next_bits;

	// Chain level walks up sixteen places before it leaves the top
	assign next_bits = load_in ? load_data_in :
		shift_in ? {bits[14:0], chain_in} : bits;
	assign msb_out = bits[15];

	// Shift register
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bits <= 16'h0000;
		end else begin
			bits <= next_bits;
		end
	end
endmodule
`default_nettype wire

// [src/aopc_top.sv]
/*
 Result port of a 16 bit converter: AHB-Lite registers, parallel bus,
 serial port and pin sharing between them.
 Assumes one AHB-Lite master, synchronous pin inputs and selects held
 steady during a frame.
*/
`timescale 1ns/100ps
`default_nettype none
module aopc_top (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic [15:0] data_bus_in,
	output logic [15:0] data_bus_out,
	output logic [15:0] data_bus_oe_out,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_out,
	output logic frame_sync_out,
	output logic serial_result_out
);
	logic rst_meta, rstn;
	aopc_pkg::aopc_ctrl_t ctrl;
	aopc_pkg::aopc_scfg_t scfg;
	aopc_pkg::aopc_state_t state, next_state;
	logic [15:0] result;
	logic busy;
	logic ph_wr, ph_write;
	logic [7:0] ph_addr;
	logic [31:0] next_rdata;
	logic serial, master, div_on, start, stop;
	logic [15:0] coded, next_bus;
	logic [3:0] half, half_cnt;
	logic sclk_int, sclk_eff, sclk_prev, ext_fall, int_rise, int_fall;
	logic [5:0] bit_cnt;
	logic shift, load, wr_result, wr_cmd, wr_ctrl;
	logic [15:0] load_word;

	// Reset release through two flops
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rstn <= rst_meta;
		end
	end

	// Bus decode; every access is zero wait and OKAY
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign wr_ctrl = ph_write && ph_addr == aopc_pkg::ADDR_CTRL;
	assign wr_result = ph_write && ph_addr == aopc_pkg::ADDR_RESULT;
	assign wr_cmd = ph_write && ph_addr == aopc_pkg::ADDR_CMD
		&& hwdata_in[aopc_pkg::CMD_START];
	assign ph_wr = hsel_in && hready_in && htrans_in[1];
	assign next_rdata = (haddr_in[7:0] == aopc_pkg::ADDR_CTRL) ? {29'h0, ctrl} :
		(haddr_in[7:0] == aopc_pkg::ADDR_RESULT) ? {16'h0000, result} :
		(haddr_in[7:0] == aopc_pkg::ADDR_STATUS) ?
		{18'h0_0000, bit_cnt, scfg, state == aopc_pkg::ST_RUN, busy} : 32'h0000_0000;

	// Address phase capture and read data
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
			hrdata_out <= 32'h0000_0000;
		end else begin
			ph_write <= ph_wr && hwrite_in;
			ph_addr <= haddr_in[7:0];
			if (ph_wr && !hwrite_in) begin
				hrdata_out <= next_rdata;
			end
		end
	end

	// Software registers; a result write ends the conversion
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			ctrl <= aopc_pkg::CTRL_RESET;
			result <= aopc_pkg::RESULT_RESET;
			busy <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= hwdata_in[2:0];
			end
			if (wr_result) begin
				result <= hwdata_in[15:0];
			end
			busy <= wr_cmd ? 1'b1 : (wr_result ? 1'b0 : busy);
		end
	end

	// Mode and shared pin selects; parallel mode sees default selects
	assign serial = ctrl.port_type;
	assign scfg = serial ? data_bus_in[7:2] : 6'h00;
	assign master = serial && !scfg.ext_clk;
	assign div_on = master && !scfg.timing_chain;

	// Output coding and byte placement
	assign coded = {result[15] ^ !ctrl.coding, result[14:0]};
	assign next_bus = ctrl.byte_order ? {coded[7:0], coded[15:8]} : coded;

	// Parallel bus drive; serial mode floats data and select pins
	assign data_bus_oe_out = serial ? 16'h0000 : 16'hFFFF;
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			data_bus_out <= 16'h0000;
		end else begin
			data_bus_out <= next_bus;
		end
	end

	// Internal clock half period from the divider code
	assign half = !div_on ? aopc_pkg::HALF_0 :
		(scfg.div == 2'd0) ? aopc_pkg::HALF_0 :
		(scfg.div == 2'd1) ? aopc_pkg::HALF_1 :
		(scfg.div == 2'd2) ? aopc_pkg::HALF_2 : aopc_pkg::HALF_3;

	// Frame start: during conversion in master chain mode, otherwise after it
	assign start = state == aopc_pkg::ST_IDLE && serial &&
		((master && scfg.timing_chain) ? wr_cmd : wr_result);
	assign int_rise = master && half_cnt == 4'd1 && !sclk_int;
	assign int_fall = master && half_cnt == 4'd1 && sclk_int;
	assign sclk_eff = sclk_in ^ scfg.sclk_inv;
	assign ext_fall = !master && sclk_prev && !sclk_eff;
	assign shift = state == aopc_pkg::ST_RUN && (int_fall || ext_fall);
	assign load = start;
	// A result write ships the word being written; a start ships the stored one
	assign load_word = wr_result ?
		{hwdata_in[15] ^ !ctrl.coding, hwdata_in[14:0]} : coded;
	assign stop = shift && bit_cnt == (master ? aopc_pkg::MASTER_BITS :
		aopc_pkg::SLAVE_BITS);

	// Frame state machine
	always_comb begin
		case (state)
			aopc_pkg::ST_IDLE: next_state = start ? aopc_pkg::ST_RUN : aopc_pkg::ST_IDLE;
			aopc_pkg::ST_RUN: next_state = (stop || !serial) ? aopc_pkg::ST_IDLE :
				aopc_pkg::ST_RUN;
			default: next_state = aopc_pkg::ST_IDLE;
		endcase
	end

	// Serial clock generator and bit counter
	always_ff @(posedge clk_in or negedge rstn) begin
		if (!rstn) begin
			state <= aopc_pkg::ST_IDLE;
			half_cnt <= 4'd1;
			sclk_int <= 1'b0;
			sclk_prev <= 1'b0;
			bit_cnt <= 6'd0;
		end else begin
			state <= next_state;
			sclk_prev <= sclk_eff;
			if (state != aopc_pkg::ST_RUN) begin
				half_cnt <= half;
				sclk_int <= 1'b0;
				bit_cnt <= 6'd0;
			end else begin
				half_cnt <= (half_cnt == 4'd1) ? half : half_cnt - 4'd1;
				if (int_rise || int_fall) begin
					sclk_int <= !sclk_int;
				end
				if (int_rise || (!master && !sclk_prev && sclk_eff)) begin
					bit_cnt <= bit_cnt + 6'd1;
				end
			end
		end
	end

	// Serial pins
	assign sclk_out = sclk_int ^ scfg.sclk_inv;
	assign sclk_oe_out = master;
	assign frame_sync_out = (state == aopc_pkg::ST_RUN) ^ scfg.fs_pol;

	aopc_shifter u_shifter (
		.clk_in(clk_in),
		.rstn_in(rstn),
		.load_in(load),
		.load_data_in(load_word),
		.shift_in(shift),
		.chain_in(scfg.timing_chain),
		.msb_out(serial_result_out)
	);

	// Checks on pin muxing and serial timing
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn);

	a_par_drive: assert property (!serial |-> data_bus_oe_out == 16'hFFFF)
		else $error("parallel bus not driven");
	a_low_float: assert property (serial |-> data_bus_oe_out[1:0] == 2'b00)
		else $error("bits 0 and 1 driven in serial mode");
	a_shared_input: assert property (serial |-> data_bus_oe_out[6:2] == 5'h00)
		else $error("select pins driven in serial mode");
	a_byte_order: assert property ($stable(ctrl) && $stable(result) && ctrl.byte_order
		|=> data_bus_out[7:0] == $past(coded[15:8]))
		else $error("bytes not swapped");
	a_msb_coding: assert property (!ctrl.byte_order && !ctrl.coding && $stable(ctrl)
		|=> data_bus_out[15] != $past(result[15]))
		else $error("msb not inverted for twos complement");
	a_clk_drive: assert property (sclk_oe_out == (serial && !scfg.ext_clk))
		else $error("clock pin drive wrong");
	a_sync_idle: assert property (state == aopc_pkg::ST_IDLE |->
		frame_sync_out == scfg.fs_pol)
		else $error("idle frame sync level wrong");
	a_clk_invert: assert property (master && state == aopc_pkg::ST_IDLE |->
		sclk_out == scfg.sclk_inv)
		else $error("idle clock polarity wrong");
	a_slow_clock: assert property (state == aopc_pkg::ST_RUN && div_on && scfg.div == 2'd3
		&& $stable(scfg) && $changed(sclk_int) |=> $stable(sclk_int) [*3])
		else $error("divided clock too fast");
	a_start_during: assert property (master && scfg.timing_chain && wr_cmd &&
		state == aopc_pkg::ST_IDLE |=> state == aopc_pkg::ST_RUN)
		else $error("read during conversion did not start");

	c_master_frame: cover property (master && stop);
	c_slave_frame: cover property (!master && serial && stop);
	c_swapped_bus: cover property (!serial && ctrl.byte_order && wr_result);
endmodule
`default_nettype wire
